/* hdl/mac_mgmt_params.svh */
// Constants for the PHY management and pause flow-control register block.
// Assumes inclusion by bare name from the design files.
`ifndef MAC_MGMT_PARAMS_SVH
`define MAC_MGMT_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_MGMT_ACCESS 4'h6
`define IDX_MGMT_DATA 4'h7
`define IDX_FLOW_CTL 4'h8
`define ADDR_MGMT_ACCESS 12'h018
`define ADDR_MGMT_DATA 12'h01C
`define ADDR_FLOW_CTL 12'h020

// Field positions
`define ACC_BUSY_BIT 0
`define ACC_WRITE_BIT 1
`define ACC_IDX_LO 6
`define ACC_IDX_HI 10
`define ACC_PHY_LO 11
`define ACC_PHY_HI 15
`define FLOW_BUSY_BIT 0
`define FLOW_EN_BIT 1
`define FLOW_PASS_BIT 2
`define FLOW_PT_LO 16
`define FLOW_PT_HI 31

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000

// Management clock: 10 MHz system clock / (2 * half period) = 2.5 MHz
`define MDC_HALF_CYC 8'h02
// Clause-22 frame: 32 preamble + 32 frame bits
`define MGMT_FRAME_BITS 7'h40
`define MGMT_START_WR 4'h5
`define MGMT_START_RD 4'h6
`define MGMT_TA_WR 2'h2

`endif

/* hdl/mac_mgmt_pkg.sv */
// Types shared by the management register block.
// Assumes the params header is included by the modules.
package mac_mgmt_pkg;
   typedef enum logic [1:0] {
      MG_IDLE = 2'h0,
      MG_SHIFT = 2'h1,
      MG_DONE = 2'h2
   } mgmt_state_e;

   typedef enum logic [1:0] {
      FC_IDLE = 2'h0,
      FC_PAUSE = 2'h1,
      FC_BACKP = 2'h2
   } flow_state_e;
endpackage

/* hdl/mdio_frame.sv */
// Clause-22 management frame engine: shifts one read or write on MDC/MDIO.
// Assumes one synchronous system clock; MDIO input sampled synchronously.
`timescale 1ns/1ps
`default_nettype none
`include "mac_mgmt_params.svh"

module mdio_frame #(
   parameter logic [7:0] HALF_CYC = `MDC_HALF_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Request
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [4:0] phy_addr_i,
   input wire logic [4:0] reg_idx_i,
   input wire logic [15:0] wdata_i,
   output logic done_o,
   output logic [15:0] rdata_o,
   // Pins
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic mdio_i
);
   // ----------------------------------------
   // Frame shifter
   // ----------------------------------------
   logic active_r, active_nxt;
   logic [7:0] div_r, div_nxt;
   logic [6:0] bit_r, bit_nxt;
   logic [63:0] sh_r, sh_nxt;
   logic [15:0] rd_r, rd_nxt;
   logic wr_r, wr_nxt;
   logic mdc_r, mdc_nxt;
   logic done_r, done_nxt;
   logic oe_r, oe_nxt;

   always_comb begin
      active_nxt = active_r;
      div_nxt = div_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      rd_nxt = rd_r;
      wr_nxt = wr_r;
      mdc_nxt = mdc_r;
      done_nxt = 1'b0;
      oe_nxt = oe_r;
      if (!active_r) begin
         if (start_i) begin
            active_nxt = 1'b1;
            wr_nxt = write_i;
            div_nxt = 8'h00;
            bit_nxt = 7'h00;
            mdc_nxt = 1'b0;
            oe_nxt = 1'b1;
            sh_nxt = {32'hFFFF_FFFF, write_i ? `MGMT_START_WR : `MGMT_START_RD, phy_addr_i, reg_idx_i,
                      `MGMT_TA_WR, write_i ? wdata_i : 16'hFFFF};
         end
      end else if (div_r == HALF_CYC - 8'h01) begin
         div_nxt = 8'h00;
         mdc_nxt = !mdc_r;
         if (mdc_r) begin
            // Falling edge: advance to the next bit
            sh_nxt = {sh_r[62:0], 1'b1};
            bit_nxt = bit_r + 7'h01;
            // Release the line from the turnaround onward on reads
            if (!wr_r && bit_r == 7'h2D) begin
               oe_nxt = 1'b0;
            end
            if (bit_r == `MGMT_FRAME_BITS - 7'h01) begin
               active_nxt = 1'b0;
               done_nxt = 1'b1;
               oe_nxt = 1'b0;
            end
         end else if (!wr_r && bit_r >= 7'h30) begin
            // Rising edge: PHY data is stable, capture it
            rd_nxt = {rd_r[14:0], mdio_i};
         end
      end else begin
         div_nxt = div_r + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         active_r <= 1'b0;
         div_r <= 8'h00;
         bit_r <= 7'h00;
         sh_r <= 64'h0000_0000_0000_0000;
         rd_r <= `RST_HALF;
         wr_r <= 1'b0;
         mdc_r <= 1'b0;
         done_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         active_r <= active_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         mdc_r <= mdc_nxt;
         done_r <= done_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign done_o = done_r;
   assign rdata_o = rd_r;
   assign mdc_o = mdc_r;
   assign mdio_o = sh_r[63];
   assign mdio_oe_o = oe_r;
endmodule
`default_nettype wire

/* hdl/mac_mgmt_flow.sv */
// PHY management access and pause/back-pressure flow-control registers.
// Assumes an APB master on sys_clk_i, a clause-22 PHY on MDC/MDIO and a MAC
// transmit/receive datapath that handshakes pause sends and reports pause frames.
//
// Behaviour
// - Register index field selects the PHY register for the cycle.
// - Write-select one writes data register out; zero reads into it.
// - Busy stays one for the whole access, cleared on completion.
// - Data register holds 16 bits in its low half; upper reserved.
// - Programmed pause time goes into every transmitted pause frame.
// - Full duplex: flow busy held until pause frame fully sent.
// - Half duplex: flow busy held while back pressure is asserted.
// - No pause frames or back pressure while transmitter disabled.
// - Enable governs receive pause and half-duplex back pressure; pass bit alters only the pause-frame filter indication.
// - Pass bit one leaves the filter indication of received pause frames unchanged.
// - Pause executed only in full duplex with enable set.
// - Pass bit zero clears filter indication of received pause frames.
// - Every received frame's data goes to the application.
// - Address filter modes like promiscuous override the pass bit.
// - Full duplex pauses transmit for pause time slots; half enables backpressure.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mac_mgmt_params.svh"

module mac_mgmt_flow #(
   parameter logic [7:0] MDC_HALF = `MDC_HALF_CYC,
   parameter logic [15:0] SLOT_CYC = 16'h0200
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // MAC mode and flow requests
   input wire logic full_duplex_i,
   input wire logic tx_enable_i,
   input wire logic flow_req_i,
   input wire logic pause_sent_i,
   // Pause frame transmit request, back pressure and transmit pause status
   output logic pause_tx_req_o,
   output logic [15:0] pause_tx_time_o,
   output logic backpressure_o,
   output logic tx_paused_o,
   // Receive status path
   input wire logic rx_valid_i,
   input wire logic rx_is_pause_i,
   input wire logic [15:0] rx_pause_time_i,
   input wire logic rx_filter_pass_i,
   input wire logic promisc_i,
   output logic rx_valid_o,
   output logic rx_filter_pass_o,
   // PHY management pins
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic mdio_i
);
   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic wr_en, rd_en;
   logic hit_acc, hit_data, hit_flow;
   assign hit_acc = (paddr_i == `ADDR_MGMT_ACCESS);
   assign hit_data = (paddr_i == `ADDR_MGMT_DATA);
   assign hit_flow = (paddr_i == `ADDR_FLOW_CTL);
   // Zero-wait slave: the access phase itself completes the transfer
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && !penable_i && !pwrite_i;

   // ----------------------------------------
   // Management access registers
   // ----------------------------------------
   mac_mgmt_pkg::mgmt_state_e mg_r, mg_nxt;
   logic [4:0] phy_addr_r, phy_addr_nxt;
   logic [4:0] reg_idx_r, reg_idx_nxt;
   logic wsel_r, wsel_nxt;
   logic [15:0] data_r, data_nxt;
   logic start;
   logic eng_done;
   logic [15:0] eng_rdata;

   always_comb begin
      mg_nxt = mg_r;
      phy_addr_nxt = phy_addr_r;
      reg_idx_nxt = reg_idx_r;
      wsel_nxt = wsel_r;
      data_nxt = data_r;
      start = 1'b0;
      unique case (mg_r)
         mac_mgmt_pkg::MG_IDLE: begin
            // Writes while busy are ignored so the frame in flight stays intact
            if (wr_en && hit_data) begin
               data_nxt = pwdata_i[15:0];
            end
            if (wr_en && hit_acc) begin
               phy_addr_nxt = pwdata_i[`ACC_PHY_HI:`ACC_PHY_LO];
               reg_idx_nxt = pwdata_i[`ACC_IDX_HI:`ACC_IDX_LO];
               wsel_nxt = pwdata_i[`ACC_WRITE_BIT];
               if (pwdata_i[`ACC_BUSY_BIT]) begin
                  mg_nxt = mac_mgmt_pkg::MG_SHIFT;
                  start = 1'b1;
               end
            end
         end
         mac_mgmt_pkg::MG_SHIFT: begin
            if (eng_done) begin
               if (!wsel_r) begin
                  data_nxt = eng_rdata;
               end
               mg_nxt = mac_mgmt_pkg::MG_IDLE;
            end
         end
         default: begin
            mg_nxt = mac_mgmt_pkg::MG_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mg_r <= mac_mgmt_pkg::MG_IDLE;
         phy_addr_r <= 5'h00;
         reg_idx_r <= 5'h00;
         wsel_r <= 1'b0;
         data_r <= `RST_HALF;
      end else begin
         mg_r <= mg_nxt;
         phy_addr_r <= phy_addr_nxt;
         reg_idx_r <= reg_idx_nxt;
         wsel_r <= wsel_nxt;
         data_r <= data_nxt;
      end
   end

   mdio_frame #(
      .HALF_CYC(MDC_HALF)
   ) u_frame (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(start),
      .write_i(pwdata_i[`ACC_WRITE_BIT]),
      .phy_addr_i(pwdata_i[`ACC_PHY_HI:`ACC_PHY_LO]),
      .reg_idx_i(pwdata_i[`ACC_IDX_HI:`ACC_IDX_LO]),
      .wdata_i(data_r),
      .done_o(eng_done),
      .rdata_o(eng_rdata),
      .mdc_o(mdc_o),
      .mdio_o(mdio_o),
      .mdio_oe_o(mdio_oe_o),
      .mdio_i(mdio_i)
   );

   // ----------------------------------------
   // Flow control
   // ----------------------------------------
   mac_mgmt_pkg::flow_state_e fc_r, fc_nxt;
   logic [15:0] pause_time_r, pause_time_nxt;
   logic fc_en_r, fc_en_nxt;
   logic pass_r, pass_nxt;
   logic ptx_r, ptx_nxt;
   logic bp_r, bp_nxt;
   logic [15:0] quanta_r, quanta_nxt;
   logic [15:0] slot_r, slot_nxt;
   logic busy_fc;
   assign busy_fc = (fc_r != mac_mgmt_pkg::FC_IDLE);

   always_comb begin
      fc_nxt = fc_r;
      pause_time_nxt = pause_time_r;
      fc_en_nxt = fc_en_r;
      pass_nxt = pass_r;
      ptx_nxt = 1'b0;
      bp_nxt = 1'b0;
      quanta_nxt = quanta_r;
      slot_nxt = slot_r;
      if (wr_en && hit_flow && !busy_fc) begin
         pause_time_nxt = pwdata_i[`FLOW_PT_HI:`FLOW_PT_LO];
         fc_en_nxt = pwdata_i[`FLOW_EN_BIT];
         pass_nxt = pwdata_i[`FLOW_PASS_BIT];
      end
      unique case (fc_r)
         mac_mgmt_pkg::FC_IDLE: begin
            if (flow_req_i && tx_enable_i) begin
               fc_nxt = full_duplex_i ? mac_mgmt_pkg::FC_PAUSE : mac_mgmt_pkg::FC_BACKP;
               ptx_nxt = full_duplex_i;
               bp_nxt = !full_duplex_i && fc_en_r;
               if (!full_duplex_i && !fc_en_r) begin
                  fc_nxt = mac_mgmt_pkg::FC_IDLE;
               end
            end
         end
         mac_mgmt_pkg::FC_PAUSE: begin
            ptx_nxt = !pause_sent_i && tx_enable_i;
            if (pause_sent_i || !tx_enable_i) begin
               fc_nxt = mac_mgmt_pkg::FC_IDLE;
            end
         end
         mac_mgmt_pkg::FC_BACKP: begin
            bp_nxt = flow_req_i && tx_enable_i && fc_en_r && !full_duplex_i;
            if (!bp_nxt) begin
               fc_nxt = mac_mgmt_pkg::FC_IDLE;
            end
         end
         default: begin
            fc_nxt = mac_mgmt_pkg::FC_IDLE;
         end
      endcase
      // Received pause: count quanta of one slot each
      if (rx_valid_i && rx_is_pause_i && full_duplex_i && fc_en_r) begin
         quanta_nxt = rx_pause_time_i;
         slot_nxt = 16'h0000;
      end else if (quanta_r != 16'h0000) begin
         if (slot_r == SLOT_CYC - 16'h0001) begin
            slot_nxt = 16'h0000;
            quanta_nxt = quanta_r - 16'h0001;
         end else begin
            slot_nxt = slot_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         fc_r <= mac_mgmt_pkg::FC_IDLE;
         pause_time_r <= `RST_HALF;
         fc_en_r <= 1'b0;
         pass_r <= 1'b0;
         ptx_r <= 1'b0;
         bp_r <= 1'b0;
         quanta_r <= `RST_HALF;
         slot_r <= `RST_HALF;
      end else begin
         fc_r <= fc_nxt;
         pause_time_r <= pause_time_nxt;
         fc_en_r <= fc_en_nxt;
         pass_r <= pass_nxt;
         ptx_r <= ptx_nxt;
         bp_r <= bp_nxt;
         quanta_r <= quanta_nxt;
         slot_r <= slot_nxt;
      end
   end

   // ----------------------------------------
   // Receive status and outputs
   // ----------------------------------------
   logic rxv_r, rxf_r, paused_r, tt_r;
   logic [15:0] ptime_r;
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rxv_r <= 1'b0;
         rxf_r <= 1'b0;
         paused_r <= 1'b0;
         ptime_r <= `RST_HALF;
      end else begin
         rxv_r <= rx_valid_i;
         // Promiscuous wins over the pass bit
         rxf_r <= promisc_i ? 1'b1 : (rx_is_pause_i ? (rx_filter_pass_i && pass_r) : rx_filter_pass_i);
         paused_r <= (quanta_nxt != 16'h0000);
         ptime_r <= pause_time_nxt;
      end
   end
   assign tt_r = 1'b0;

   // APB read data registered in the setup phase
   logic [31:0] rdata_r, rdata_nxt;
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_en) begin
         rdata_nxt = `RST_WORD;
         if (hit_acc) begin
            rdata_nxt[`ACC_PHY_HI:`ACC_PHY_LO] = phy_addr_r;
            rdata_nxt[`ACC_IDX_HI:`ACC_IDX_LO] = reg_idx_r;
            rdata_nxt[`ACC_WRITE_BIT] = wsel_r;
            rdata_nxt[`ACC_BUSY_BIT] = (mg_r != mac_mgmt_pkg::MG_IDLE);
         end else if (hit_data) begin
            rdata_nxt[15:0] = data_r;
         end else if (hit_flow) begin
            rdata_nxt[`FLOW_PT_HI:`FLOW_PT_LO] = pause_time_r;
            rdata_nxt[`FLOW_PASS_BIT] = pass_r;
            rdata_nxt[`FLOW_EN_BIT] = fc_en_r;
            rdata_nxt[`FLOW_BUSY_BIT] = busy_fc;
         end
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= `RST_WORD;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign prdata_o = rdata_r;
   assign pready_o = 1'b1;
   assign pslverr_o = tt_r;
   assign pause_tx_req_o = ptx_r;
   assign pause_tx_time_o = ptime_r;
   assign backpressure_o = bp_r;
   assign tx_paused_o = paused_r;
   assign rx_valid_o = rxv_r;
   assign rx_filter_pass_o = rxf_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   mgmt_busy_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (mg_r == mac_mgmt_pkg::MG_SHIFT && !eng_done) |=> (mg_r == mac_mgmt_pkg::MG_SHIFT))
      else $error("management busy dropped early");
   mgmt_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(mg_r == mac_mgmt_pkg::MG_SHIFT) |-> $past(wr_en && hit_acc && pwdata_i[`ACC_BUSY_BIT]))
      else $error("management cycle without busy write");
   read_data_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (eng_done && !wsel_r && mg_r == mac_mgmt_pkg::MG_SHIFT) |=> (data_r == $past(eng_rdata)))
      else $error("read data not loaded");
   no_tx_flow_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !tx_enable_i |=> (!pause_tx_req_o && !backpressure_o))
      else $error("flow action with transmitter off");
   pause_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pause_tx_req_o |-> busy_fc)
      else $error("pause sent without flow busy");
   pause_time_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pause_tx_req_o |-> (pause_tx_time_o == pause_time_r))
      else $error("pause time mismatch");
   pass_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (rx_is_pause_i && !pass_r && !promisc_i) |=> !rx_filter_pass_o)
      else $error("pause filter bit not cleared");
   forward_all_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rx_valid_i |=> rx_valid_o)
      else $error("frame not forwarded");
endmodule
`default_nettype wire

/* verif/phy_mdio_model.sv */
// PHY side of the management link: clause-22 slave with 32 registers.
// Assumes the block's MDC/MDIO pins; a released MDIO line floats high.
`timescale 1ns/1ps
`default_nettype none
module phy_mdio_model (
   // Pins of the block
   input wire logic mdc_i,
   input wire logic mdio_drv_i,
   input wire logic mdio_oe_i,
   output logic mdio_wire_o,
   // Last frame seen
   output logic [4:0] phy_addr_o,
   output logic [4:0] reg_idx_o,
   output logic [15:0] wdata_o,
   output logic [7:0] bad_o
);
   logic [15:0] mem [32];
   logic [12:0] hdr;
   logic [15:0] sh;
   logic drv;
   logic bit_v;
   int ones;
   // Pull-up wins when nobody drives
   assign mdio_wire_o = mdio_oe_i ? mdio_drv_i : (drv ? bit_v : 1'b1);
   // ----------------------------------------
   // Frame decoder
   // ----------------------------------------
   initial begin
      drv = 1'b0;
      bit_v = 1'b1;
      bad_o = 8'h00;
      foreach (mem[i]) mem[i] = 16'h0000;
      forever begin
         ones = 0;
         forever begin
            @(posedge mdc_i);
            if (mdio_oe_i && mdio_drv_i) begin
               ones++;
            end else if (mdio_oe_i && ones >= 32) begin
               break;
            end else begin
               ones = 0;
            end
         end
         for (int i = 0; i < 13; i++) begin
            @(posedge mdc_i);
            hdr = {hdr[11:0], mdio_drv_i};
         end
         phy_addr_o = hdr[9:5];
         reg_idx_o = hdr[4:0];
         if (hdr[12] !== 1'b1 || hdr[11] === hdr[10]) bad_o++;
         if (hdr[11:10] == 2'b01) begin
            for (int i = 0; i < 18; i++) begin
               @(posedge mdc_i);
               sh = {sh[14:0], mdio_drv_i};
            end
            mem[hdr[4:0]] = sh;
            wdata_o = sh;
         end else begin
            // Data changes on the falling edge so it is stable at every rise
            @(posedge mdc_i);
            @(negedge mdc_i);
            drv <= 1'b1;
            bit_v <= 1'b0;
            for (int i = 15; i >= 0; i--) begin
               @(negedge mdc_i);
               bit_v <= mem[hdr[4:0]][i];
            end
            @(negedge mdc_i);
            drv <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/mac_phy_mgmt_and_pause_ctl_test.sv */
// Self-checking bench for the PHY management and pause flow-control block.
// Assumes the APB slave, MDC/MDIO pins and MAC flow ports of the block.
`timescale 1ns/1ps
`default_nettype none
`include "mac_mgmt_params.svh"
module mac_phy_mgmt_and_pause_ctl_test;
   localparam logic [15:0] SLOT = 16'h0004;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic full_duplex, tx_enable, flow_req, pause_sent, pause_req, bp, tx_paused;
   logic [15:0] pause_time, rx_time, pt, wd, q;
   logic rx_valid, rx_pause, rx_fp, promisc, rx_valid_q, rx_pass_q;
   logic mdc, mdio_out, mdio_oe, mdio_in;
   logic [4:0] m_phy, m_idx, idx;
   logic [15:0] m_wdata;
   logic [7:0] m_bad;
   int miscompares = 0, n_checks = 0, cyc = 0, seed = 48, n;
   mac_mgmt_flow #(.SLOT_CYC(SLOT)) dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .full_duplex_i(full_duplex),
      .tx_enable_i(tx_enable), .flow_req_i(flow_req), .pause_sent_i(pause_sent),
      .pause_tx_req_o(pause_req), .pause_tx_time_o(pause_time), .backpressure_o(bp),
      .tx_paused_o(tx_paused), .rx_valid_i(rx_valid), .rx_is_pause_i(rx_pause),
      .rx_pause_time_i(rx_time), .rx_filter_pass_i(rx_fp), .promisc_i(promisc),
      .rx_valid_o(rx_valid_q), .rx_filter_pass_o(rx_pass_q), .mdc_o(mdc), .mdio_o(mdio_out),
      .mdio_oe_o(mdio_oe), .mdio_i(mdio_in));
   phy_mdio_model phy_u (.mdc_i(mdc), .mdio_drv_i(mdio_out), .mdio_oe_i(mdio_oe),
      .mdio_wire_o(mdio_in), .phy_addr_o(m_phy), .reg_idx_o(m_idx), .wdata_o(m_wdata), .bad_o(m_bad));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         conclude();
      end
   end
   function automatic logic [31:0] fl(input logic [15:0] t, input logic p, input logic e, input logic b);
      return {t, 13'h0000, p, e, b};
   endfunction
   function automatic logic exp_pass(input logic p, input logic pr, input logic ip, input logic fp);
      return pr ? 1'b1 : (ip ? (p && fp) : fp);
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic mgmt(input logic wr, input logic [4:0] i);
      int t0;
      t0 = cyc;
      apb(1'b1, `ADDR_MGMT_ACCESS, {16'h0000, 5'b00001, i, 4'h0, wr, 1'b1});
      // Refused while busy, so the frame keeps the earlier data
      apb(1'b1, `ADDR_MGMT_DATA, 32'h0000_0bad);
      apb(1'b0, `ADDR_MGMT_ACCESS, 32'h0000_0000);
      chk("access busy", 32'h0000_0001, {31'h0, rd[0]});
      while (rd[0] === 1'b1) begin
         apb(1'b0, `ADDR_MGMT_ACCESS, 32'h0000_0000);
      end
      chk("busy span", 32'h0000_0001, {31'h0, (cyc - t0 > 200) && (cyc - t0 < 400)});
   endtask
   task automatic rxf(input logic ip, input logic fp, input logic pr, input logic [15:0] t);
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_pause <= ip;
      rx_fp <= fp;
      promisc <= pr;
      rx_time <= t;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
      {full_duplex, tx_enable, flow_req, pause_sent} = '0;
      {rx_valid, rx_pause, rx_fp, promisc, rx_time} = '0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b1, 12'h024, $random(seed));
      for (int a = 6; a < 10; a++) begin
         apb(1'b0, 12'(a * 4), 32'h0000_0000);
         chk("reset value", 32'h0000_0000, rd);
      end
      for (int k = 0; k < 4; k++) begin
         idx = (k == 0) ? 5'h00 : (k == 3) ? 5'h1f : 5'($random(seed));
         wd = (k == 0) ? 16'hffff : 16'($random(seed));
         apb(1'b1, `ADDR_MGMT_DATA, {16'hffff, wd});
         apb(1'b0, `ADDR_MGMT_DATA, 32'h0000_0000);
         chk("data reg", {16'h0000, wd}, rd);
         mgmt(1'b1, idx);
         chk("phy address", 32'h0000_0001, {27'h0, m_phy});
         chk("reg index", {27'h0, idx}, {27'h0, m_idx});
         chk("write data", {16'h0000, wd}, {16'h0000, m_wdata});
         apb(1'b1, `ADDR_MGMT_DATA, 32'h0000_0000);
         mgmt(1'b0, idx);
         apb(1'b0, `ADDR_MGMT_DATA, 32'h0000_0000);
         chk("read data", {16'h0000, wd}, rd);
      end
      chk("frame format", 32'h0000_0000, {24'h0, m_bad});
      pt = 16'($random(seed));
      apb(1'b1, `ADDR_FLOW_CTL, fl(pt, 1'b0, 1'b1, 1'b0));
      apb(1'b0, `ADDR_FLOW_CTL, 32'h0000_0000);
      chk("flow reg", fl(pt, 1'b0, 1'b1, 1'b0), rd);
      full_duplex <= 1'b1;
      tx_enable <= 1'b1;
      flow_req <= 1'b1;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("pause req", 32'h0000_0001, {31'h0, pause_req});
      chk("pause time", {16'h0000, pt}, {16'h0000, pause_time});
      apb(1'b1, `ADDR_FLOW_CTL, 32'h0000_0006);
      apb(1'b0, `ADDR_FLOW_CTL, 32'h0000_0000);
      chk("flow busy", fl(pt, 1'b0, 1'b1, 1'b1), rd);
      flow_req <= 1'b0;
      pause_sent <= 1'b1;
      @(posedge sys_clk);
      pause_sent <= 1'b0;
      apb(1'b0, `ADDR_FLOW_CTL, 32'h0000_0000);
      chk("flow idle", fl(pt, 1'b0, 1'b1, 1'b0), rd);
      tx_enable <= 1'b0;
      flow_req <= 1'b1;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("tx off", 32'h0000_0000, {30'h0, pause_req, bp});
      @(posedge sys_clk);
      full_duplex <= 1'b0;
      tx_enable <= 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("backpressure", 32'h0000_0001, {31'h0, bp});
      apb(1'b0, `ADDR_FLOW_CTL, 32'h0000_0000);
      chk("bp busy", fl(pt, 1'b0, 1'b1, 1'b1), rd);
      flow_req <= 1'b0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("bp off", 32'h0000_0000, {31'h0, bp});
      @(posedge sys_clk);
      full_duplex <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         apb(1'b1, `ADDR_FLOW_CTL, fl(pt, k[3], 1'b0, 1'b0));
         rxf(k[2], k[1], k[0], 16'h0003);
         @(negedge sys_clk);
         chk("rx valid", 32'h0000_0001, {31'h0, rx_valid_q});
         chk("rx pass", {31'h0, exp_pass(k[3], k[0], k[2], k[1])}, {31'h0, rx_pass_q});
      end
      chk("no pause", 32'h0000_0000, {31'h0, tx_paused});
      for (int d = 0; d < 2; d++) begin
         q = 16'(1 + ($random(seed) & 3));
         apb(1'b1, `ADDR_FLOW_CTL, fl(pt, 1'b1, 1'b1, 1'b0));
         full_duplex <= d[0];
         rxf(1'b1, 1'b1, 1'b0, q);
         n = 0;
         repeat (40) begin
            @(negedge sys_clk);
            n += (tx_paused === 1'b1);
         end
         chk("pause span", d ? 32'(q * SLOT) : 32'h0000_0000, 32'(n));
      end
      conclude();
   end
endmodule
`default_nettype wire
